// file: ipw_pkg.sv
// Package: entry field positions, widths and walk encodings
package ipw_pkg;
  localparam int unsigned ENTRY_W = 64;
  localparam int unsigned HAW_DEFAULT = 48;
  localparam int unsigned RSV_TOP = 51;
  localparam int unsigned BIT_PRESENT = 0;
  localparam int unsigned BIT_RW = 1;
  localparam int unsigned BIT_US = 2;
  localparam int unsigned BIT_WTHRU = 3;
  localparam int unsigned BIT_CACHEOFF = 4;
  localparam int unsigned BIT_USED = 5;
  localparam int unsigned BIT_DIRTY = 6;
  localparam int unsigned BIT_LEAF = 7;
  localparam int unsigned BIT_EXTUSED = 10;
  localparam int unsigned BIT_ATTR = 12;
  localparam int unsigned BIT_XD = 63;
  localparam int unsigned DIR_BASE_LO = 12;
  localparam int unsigned PAGE2M_BASE_LO = 21;
  localparam int unsigned RSV2M_HI = 20;
  localparam int unsigned RSV2M_LO = 13;
  localparam int unsigned GIG_BASE_LO = 30;
  localparam int unsigned RSV1G_HI = 29;
  // Level of entry being decoded
  localparam logic [1:0] LVL_DIRPTR = 2'h0;
  localparam logic [1:0] LVL_DIR = 2'h1;
  // Outcome kind
  typedef enum logic [2:0] {
    OUT_NEXT_TABLE = 3'h0,
    OUT_PAGE_1G = 3'h1,
    OUT_PAGE_2M = 3'h2,
    OUT_NOT_PRESENT = 3'h3,
    OUT_MALFORMED = 3'h4,
    OUT_DENIED = 3'h5
  } ipw_outcome_type;
  // Walker states, Gray along idle -> decode -> update -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DECODE = 2'b01,
    ST_UPDATE = 2'b11,
    ST_DONE = 2'b10
  } ipw_state_type;
endpackage

// file: ipw_perm.sv
// Permission check for one entry level
`timescale 1ns/1ps
`default_nettype none
module ipw_perm (
  // Entry bits
  input wire logic rw_i,
  input wire logic us_i,
  input wire logic xd_i,
  // Request and context
  input wire logic user_i,
  input wire logic write_i,
  input wire logic exec_i,
  input wire logic exec_deny_enable_i,
  input wire logic supervisor_wprotect_enable_i,
  // Result
  output logic deny_o
);
  logic deny_user;
  logic deny_write;
  logic deny_exec;
  assign deny_user = user_i && !us_i;
  assign deny_write = write_i && !rw_i && (user_i || supervisor_wprotect_enable_i);
  assign deny_exec = exec_i && exec_deny_enable_i && xd_i;
  assign deny_o = deny_user || deny_write || deny_exec;
endmodule
`default_nettype wire

// file: ipw_walk_decode.sv
// Page-walk entry decoder for directory-pointer and directory level entries
`timescale 1ns/1ps
`default_nettype none
module ipw_walk_decode #(
  parameter int unsigned HOST_ADDR_WIDTH = ipw_pkg::HAW_DEFAULT
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Request
  input wire logic start_i,
  input wire logic [1:0] level_i,
  input wire logic [63:0] entry_i,
  input wire logic user_i,
  input wire logic write_i,
  input wire logic exec_i,
  // Context enables
  input wire logic exec_deny_enable_i,
  input wire logic supervisor_wprotect_enable_i,
  input wire logic ext_used_enable_i,
  input wire logic two_stage_enable_i,
  input wire logic coherent_i,
  // Atomic update port toward memory
  output logic upd_valid_o,
  output logic [63:0] upd_entry_o,
  input wire logic upd_ready_i,
  // Result
  output logic busy_o,
  output logic done_o,
  output logic [2:0] outcome_o,
  output logic [63:0] addr_o,
  output logic addr_is_guest_o,
  output logic [2:0] mem_hint_o,
  output logic exec_ok_o,
  output logic write_ok_o
);
  typedef struct packed {
    ipw_pkg::ipw_state_type state;
    logic [63:0] entry;
    logic [1:0] level;
    logic user;
    logic write;
    logic exec;
    logic [2:0] outcome;
    logic [63:0] addr;
    logic guest;
    logic [2:0] hint;
    logic exec_ok;
    logic write_ok;
    logic [63:0] upd;
  } ipw_regs_type;

  ipw_regs_type r;
  ipw_regs_type next_r;

  // Mask of bits from lo up to HOST_ADDR_WIDTH-1
  function automatic logic [63:0] span_mask(input int unsigned lo);
    logic [63:0] m;
    m = '0;
    for (int i = 0; i < 64; i++) begin
      if (i >= lo && i < HOST_ADDR_WIDTH) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // Reserved bits 51 down to HOST_ADDR_WIDTH
  function automatic logic rsv_high(input logic [63:0] e);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < 64; i++) begin
      if (i >= HOST_ADDR_WIDTH && i <= ipw_pkg::RSV_TOP) begin
        bad = bad | e[i];
      end
    end
    return bad;
  endfunction

  logic deny;
  logic is_leaf;
  logic is_ptr;
  logic ptr_1g;
  logic rsv_bad;
  logic [63:0] used_set;

  ipw_perm u_perm (
    .rw_i(r.entry[ipw_pkg::BIT_RW]),
    .us_i(r.entry[ipw_pkg::BIT_US]),
    .xd_i(r.entry[ipw_pkg::BIT_XD]),
    .user_i(r.user),
    .write_i(r.write),
    .exec_i(r.exec),
    .exec_deny_enable_i(exec_deny_enable_i),
    .supervisor_wprotect_enable_i(supervisor_wprotect_enable_i),
    .deny_o(deny)
  );

  always_comb begin
    is_ptr = (r.level == ipw_pkg::LVL_DIRPTR);
    is_leaf = r.entry[ipw_pkg::BIT_LEAF];
    ptr_1g = is_ptr && is_leaf;
    // Reserved checks; ignored fields 62:52, 11, 9:8 never looked at
    rsv_bad = rsv_high(r.entry);
    if (!is_ptr && is_leaf) begin
      rsv_bad = rsv_bad | (|r.entry[ipw_pkg::RSV2M_HI:ipw_pkg::RSV2M_LO]);
    end
    if (ptr_1g) begin
      rsv_bad = rsv_bad | (|r.entry[ipw_pkg::RSV1G_HI:ipw_pkg::RSV2M_LO]);
    end
    // Used flags to set on success
    used_set = r.entry;
    used_set[ipw_pkg::BIT_USED] = 1'b1;
    if (ext_used_enable_i) begin
      used_set[ipw_pkg::BIT_EXTUSED] = 1'b1;
    end
    if (!is_ptr && is_leaf && r.write) begin
      used_set[ipw_pkg::BIT_DIRTY] = 1'b1;
    end
  end

  always_comb begin
    next_r = r;
    case (r.state)
      ipw_pkg::ST_IDLE: begin
        if (start_i) begin
          next_r.entry = entry_i;
          next_r.level = level_i;
          next_r.user = user_i;
          next_r.write = write_i;
          next_r.exec = exec_i;
          next_r.state = ipw_pkg::ST_DECODE;
        end
      end
      ipw_pkg::ST_DECODE: begin
        next_r.guest = two_stage_enable_i;
        next_r.exec_ok = !(exec_deny_enable_i && r.entry[ipw_pkg::BIT_XD]);
        next_r.write_ok = r.entry[ipw_pkg::BIT_RW] || !(r.user || supervisor_wprotect_enable_i);
        // Hints matter only inside the coherency domain
        if (coherent_i) begin
          next_r.hint = {is_leaf && r.entry[ipw_pkg::BIT_ATTR],
                         r.entry[ipw_pkg::BIT_CACHEOFF], r.entry[ipw_pkg::BIT_WTHRU]};
        end else begin
          next_r.hint = 3'h0;
        end
        next_r.addr = 64'h0000_0000_0000_0000;
        next_r.upd = used_set;
        if (!r.entry[ipw_pkg::BIT_PRESENT]) begin
          next_r.outcome = ipw_pkg::OUT_NOT_PRESENT;
          next_r.state = ipw_pkg::ST_DONE;
        end else if (rsv_bad) begin
          next_r.outcome = ipw_pkg::OUT_MALFORMED;
          next_r.state = ipw_pkg::ST_DONE;
        end else if (deny) begin
          next_r.outcome = ipw_pkg::OUT_DENIED;
          next_r.state = ipw_pkg::ST_DONE;
        end else begin
          if (ptr_1g) begin
            next_r.outcome = ipw_pkg::OUT_PAGE_1G;
            next_r.addr = r.entry & span_mask(ipw_pkg::GIG_BASE_LO);
          end else if (!is_ptr && is_leaf) begin
            next_r.outcome = ipw_pkg::OUT_PAGE_2M;
            next_r.addr = r.entry & span_mask(ipw_pkg::PAGE2M_BASE_LO);
          end else begin
            next_r.outcome = ipw_pkg::OUT_NEXT_TABLE;
            next_r.addr = r.entry & span_mask(ipw_pkg::DIR_BASE_LO);
          end
          // Skip memory traffic when nothing would change
          if (used_set != r.entry) begin
            next_r.state = ipw_pkg::ST_UPDATE;
          end else begin
            next_r.state = ipw_pkg::ST_DONE;
          end
        end
      end
      ipw_pkg::ST_UPDATE: begin
        if (upd_ready_i) begin
          next_r.state = ipw_pkg::ST_DONE;
        end
      end
      ipw_pkg::ST_DONE: begin
        next_r.state = ipw_pkg::ST_IDLE;
      end
      default: begin
        next_r.state = ipw_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign upd_valid_o = (r.state == ipw_pkg::ST_UPDATE);
  assign upd_entry_o = r.upd;
  assign busy_o = (r.state != ipw_pkg::ST_IDLE);
  assign done_o = (r.state == ipw_pkg::ST_DONE);
  assign outcome_o = r.outcome;
  assign addr_o = r.addr;
  assign addr_is_guest_o = r.guest;
  assign mem_hint_o = r.hint;
  assign exec_ok_o = r.exec_ok;
  assign write_ok_o = r.write_ok;

  // Walk shapes used by the checks below
  sequence s_take;
    r.state == ipw_pkg::ST_IDLE && start_i;
  endsequence
  sequence s_decode_then_result;
    busy_o && !done_o && !upd_valid_o ##1 (done_o || upd_valid_o);
  endsequence
  sequence s_wb_accept;
    upd_valid_o && upd_ready_i;
  endsequence
  // Memory may hold ready low for any time, so only the end of a write-back is timed
  sequence s_wb_finish;
    done_o && !upd_valid_o ##1 !busy_o;
  endsequence

  // Outcome and priority
  a_absent_no_go: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.state == ipw_pkg::ST_DECODE && !r.entry[ipw_pkg::BIT_PRESENT])
      |=> done_o && outcome_o == ipw_pkg::OUT_NOT_PRESENT)
    else $error("absent entry not faulted");
  a_user_refuse: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.state == ipw_pkg::ST_DECODE && r.entry[ipw_pkg::BIT_PRESENT] && !rsv_bad
      && r.user && !r.entry[ipw_pkg::BIT_US]) |=> outcome_o == ipw_pkg::OUT_DENIED)
    else $error("user access not refused");
  a_rsv_fault: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.state == ipw_pkg::ST_DECODE && r.entry[ipw_pkg::BIT_PRESENT] && rsv_bad) |=> outcome_o == ipw_pkg::OUT_MALFORMED)
    else $error("reserved bits not faulted");
  a_dir_base: assert property (@(posedge clock_i) disable iff (rst_i)
    (done_o && outcome_o == ipw_pkg::OUT_NEXT_TABLE) |-> addr_o[ipw_pkg::DIR_BASE_LO-1:0] == '0)
    else $error("directory base misaligned");
  a_page_base: assert property (@(posedge clock_i) disable iff (rst_i)
    (done_o && outcome_o == ipw_pkg::OUT_PAGE_2M) |-> addr_o[ipw_pkg::PAGE2M_BASE_LO-1:0] == '0)
    else $error("2M base misaligned");
  a_gig_base: assert property (@(posedge clock_i) disable iff (rst_i)
    (done_o && outcome_o == ipw_pkg::OUT_PAGE_1G) |-> addr_o[ipw_pkg::GIG_BASE_LO-1:0] == '0)
    else $error("1G base misaligned");
  // Permissions and hints
  a_exec_deny: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.state == ipw_pkg::ST_DECODE && exec_deny_enable_i && r.entry[ipw_pkg::BIT_XD]) |=> !exec_ok_o)
    else $error("execute not denied");
  a_wprot_sup: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.state == ipw_pkg::ST_DECODE && supervisor_wprotect_enable_i && !r.entry[ipw_pkg::BIT_RW]) |=> !write_ok_o)
    else $error("write not denied");
  a_hint_gate: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.state == ipw_pkg::ST_DECODE && !coherent_i) |=> mem_hint_o == 3'h0)
    else $error("hint leaked");
  a_guest_flag: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.state == ipw_pkg::ST_DECODE) |=> addr_is_guest_o == $past(two_stage_enable_i))
    else $error("guest flag wrong");
  // Write-back contents
  a_used_set: assert property (@(posedge clock_i) disable iff (rst_i)
    upd_valid_o |-> upd_entry_o[ipw_pkg::BIT_USED])
    else $error("used bit not set in update");
  a_ext_gate: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.state == ipw_pkg::ST_DECODE && !ext_used_enable_i && !r.entry[ipw_pkg::BIT_EXTUSED]) |=> !upd_entry_o[ipw_pkg::BIT_EXTUSED])
    else $error("extended flag set while disabled");
  a_dirty_mark: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.state == ipw_pkg::ST_DECODE && !is_ptr && is_leaf && r.write) |=> upd_entry_o[ipw_pkg::BIT_DIRTY])
    else $error("dirty bit not set for write");
  // Handshake; a refused start must not disturb the entry under write-back
  a_update_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    (upd_valid_o && !upd_ready_i) |=> upd_valid_o && $stable(upd_entry_o))
    else $error("update dropped");
  a_take_decode: assert property (@(posedge clock_i) disable iff (rst_i)
    s_take |=> s_decode_then_result)
    else $error("walk did not decode after take");
  a_refuse_busy: assert property (@(posedge clock_i) disable iff (rst_i)
    (busy_o && start_i) |=> $stable(r.entry))
    else $error("start taken while busy");
  a_fault_no_wb: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.state == ipw_pkg::ST_DECODE && (!r.entry[ipw_pkg::BIT_PRESENT] || rsv_bad || deny))
      |=> done_o && !upd_valid_o)
    else $error("failed walk wrote back");
  a_wb_finish: assert property (@(posedge clock_i) disable iff (rst_i)
    s_wb_accept |=> s_wb_finish)
    else $error("write-back did not finish");
endmodule
`default_nettype wire

// file: ipw_mem_model.sv
// Memory model that completes atomic entry write-backs after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module ipw_mem_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Update port
  input wire logic upd_valid_i,
  input wire logic [63:0] upd_entry_i,
  input wire logic [3:0] delay_i,
  output logic upd_ready_o,
  // Observation
  output logic [63:0] last_entry_o,
  output logic [7:0] upd_cnt_o
);
  logic [3:0] wait_cnt;
  // Ready only after the delay, so a slow memory holds the walker waiting
  assign upd_ready_o = upd_valid_i && (wait_cnt >= delay_i);
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wait_cnt <= 4'h0;
      upd_cnt_o <= 8'h00;
      last_entry_o <= 64'h0000_0000_0000_0000;
    end else if (upd_ready_o) begin
      wait_cnt <= 4'h0;
      upd_cnt_o <= upd_cnt_o + 8'h01;
      last_entry_o <= upd_entry_i;
    end else if (upd_valid_i) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: tb_top.sv
// Testbench for the page-walk entry decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock_i, rst_i, start, req_u, req_w, req_x;
  logic xde, wprot, ext_used, two_stage, coherent;
  logic [1:0] level;
  logic [63:0] entry, upd_entry, addr, last_entry;
  logic upd_valid, upd_ready, busy, done, guest, exec_ok, write_ok;
  logic [2:0] outcome, hint;
  logic [3:0] delay;
  logic [7:0] upd_cnt, cnt0;
  int error_cnt = 0;
  int checks_done = 0;
  ipw_walk_decode #(.HOST_ADDR_WIDTH(48)) uut (.clock_i(clock_i), .rst_i(rst_i), .start_i(start), .level_i(level),
    .entry_i(entry), .user_i(req_u), .write_i(req_w), .exec_i(req_x), .exec_deny_enable_i(xde),
    .supervisor_wprotect_enable_i(wprot), .ext_used_enable_i(ext_used), .two_stage_enable_i(two_stage),
    .coherent_i(coherent), .upd_valid_o(upd_valid), .upd_entry_o(upd_entry), .upd_ready_i(upd_ready),
    .busy_o(busy), .done_o(done), .outcome_o(outcome), .addr_o(addr), .addr_is_guest_o(guest),
    .mem_hint_o(hint), .exec_ok_o(exec_ok), .write_ok_o(write_ok));
  ipw_mem_model mem (.clock_i(clock_i), .rst_i(rst_i), .upd_valid_i(upd_valid), .upd_entry_i(upd_entry),
    .delay_i(delay), .upd_ready_o(upd_ready), .last_entry_o(last_entry), .upd_cnt_o(upd_cnt));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request is {user, write, exec}; context is {coherent, two-stage, ext-used, wprotect, exec-deny}
  task automatic walk(input logic [1:0] lvl, input logic [63:0] ent, input logic [2:0] req,
      input logic [4:0] ctx, input logic [3:0] dly);
    int n;
    @(posedge clock_i);
    #1;
    level = lvl;
    entry = ent;
    {req_u, req_w, req_x} = req;
    {coherent, two_stage, ext_used, wprot, xde} = ctx;
    delay = dly;
    cnt0 = upd_cnt;
    start = 1'b1;
    @(posedge clock_i);
    #1;
    start = 1'b0;
    n = 0;
    // Bounded wait: a hung walk is a mismatch, not a stuck run
    while (done !== 1'b1 && n < 40) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (done !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  task automatic expect_out(input logic [1:0] lvl, input logic [63:0] ent, input logic [2:0] req,
      input logic [4:0] ctx, input logic [2:0] exp);
    walk(lvl, ent, req, ctx, 4'h0);
    chk(outcome, exp);
    chk(upd_cnt - cnt0, 8'h00);
  endtask
  task automatic s_dirptr_table();
    walk(2'h0, 64'h7FF0_8765_4321_F81F, 3'b110, 5'b11000, 4'h3);
    chk(outcome, 3'h0);
    chk(addr, 64'h0000_8765_4321_F000);
    chk(guest, 1'b1);
    chk(hint, 3'b011);
    chk(write_ok, 1'b1);
    chk(upd_cnt - cnt0, 8'h01);
    chk(last_entry, 64'h7FF0_8765_4321_F83F);
  endtask
  task automatic s_gig_leaf();
    walk(2'h0, 64'h0000_8000_4000_10BF, 3'b000, 5'b00000, 4'h0);
    chk(outcome, 3'h1);
    chk(addr, 64'h0000_8000_4000_0000);
    chk(hint, 3'b000);
    chk(upd_cnt - cnt0, 8'h00);
  endtask
  task automatic s_2m_leaf();
    walk(2'h1, 64'h0000_0000_4020_109F, 3'b111, 5'b10101, 4'h0);
    chk(outcome, 3'h2);
    chk(addr, 64'h0000_0000_4020_0000);
    chk(guest, 1'b0);
    chk(hint, 3'b111);
    chk(exec_ok, 1'b1);
    chk(last_entry[10], 1'b1);
    chk(last_entry, 64'h0000_0000_4020_14FF);
  endtask
  task automatic s_faults();
    expect_out(2'h0, 64'h0000_8765_4321_F01E, 3'b000, 5'b00000, 3'h3);
    expect_out(2'h1, 64'h0000_0000_4020_0086, 3'b000, 5'b00000, 3'h3);
    expect_out(2'h1, 64'h0000_0000_4020_2087, 3'b000, 5'b00000, 3'h4);
    expect_out(2'h0, 64'h0001_0000_0000_1027, 3'b000, 5'b00000, 3'h4);
    expect_out(2'h1, 64'h8000_0000_4020_0087, 3'b001, 5'b00001, 3'h5);
    expect_out(2'h0, 64'h8000_8765_4321_F007, 3'b001, 5'b00001, 3'h5);
    expect_out(2'h0, 64'h8000_8765_4321_F027, 3'b001, 5'b00000, 3'h0);
    expect_out(2'h0, 64'h0000_8765_4321_F003, 3'b100, 5'b00000, 3'h5);
    expect_out(2'h0, 64'h0000_8765_4321_F005, 3'b110, 5'b00000, 3'h5);
    expect_out(2'h0, 64'h0000_8765_4321_F005, 3'b010, 5'b00010, 3'h5);
    expect_out(2'h0, 64'h0000_8765_4321_F025, 3'b010, 5'b00000, 3'h0);
    expect_out(2'h1, 64'h0000_0000_4020_0027, 3'b000, 5'b00000, 3'h0);
  endtask
  // Start held high while busy is ignored; a reset in mid write-back clears everything
  task automatic s_busy_reset();
    @(posedge clock_i);
    #1;
    level = 2'h0;
    entry = 64'h0000_8765_4321_F007;
    {req_u, req_w, req_x} = 3'b000;
    {coherent, two_stage, ext_used, wprot, xde} = 5'b00000;
    delay = 4'hF;
    start = 1'b1;
    @(posedge clock_i);
    #1;
    entry = 64'h0000_0000_0000_0000;
    chk(busy, 1'b1);
    @(posedge clock_i);
    #1;
    chk(upd_valid, 1'b1);
    chk(upd_entry, 64'h0000_8765_4321_F027);
    @(posedge clock_i);
    #1;
    chk(upd_valid, 1'b1);
    start = 1'b0;
    rst_i = 1'b1;
    @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    chk(busy, 1'b0);
    chk(upd_valid, 1'b0);
    chk(outcome, 3'h0);
    chk(upd_cnt, 8'h00);
    walk(2'h0, 64'h8000_8765_4321_F005, 3'b000, 5'b00011, 4'h1);
    chk(outcome, 3'h0);
    chk(exec_ok, 1'b0);
    chk(write_ok, 1'b0);
    chk(upd_cnt - cnt0, 8'h01);
    chk(last_entry, 64'h8000_8765_4321_F025);
    @(posedge clock_i);
    #1;
    chk(done, 1'b0);
    chk(busy, 1'b0);
    chk(addr, 64'h0000_8765_4321_F000);
  endtask
  initial begin
    rst_i = 1'b1;
    start = 1'b0;
    level = 2'h0;
    entry = 64'h0000_0000_0000_0000;
    {req_u, req_w, req_x} = 3'b000;
    {coherent, two_stage, ext_used, wprot, xde} = 5'b00000;
    delay = 4'h0;
    repeat (12) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    s_dirptr_table();
    s_gig_leaf();
    s_2m_leaf();
    s_faults();
    s_busy_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
